// ===== core/fcs_ed_consts.svh
// Register offsets, field positions, reset values and timing counts for frame check and energy
`ifndef FCS_ED_CONSTS_SVH
`define FCS_ED_CONSTS_SVH

`define REG_TRX_CTRL_ONE 6'h04
`define REG_SIGNAL_STRENGTH 6'h06
`define REG_ENERGY_LEVEL 6'h07
`define CTRL_ONE_RESET 8'h20
`define CTRL_AUTO_CRC_BIT 5
`define CRC_VALID_BIT 7
`define ENERGY_RESET 8'hff
`define CRC_POLY 16'h1021
`define CRC_INIT 16'h0000
`define RSSI_MAX 5'h1c
`define FCS_MIN_LEN 7'h03

`define CLK_PERIOD_NS 20
`define RSSI_INTERVAL_BPSK20_US 32
`define RSSI_INTERVAL_BPSK40_US 24
`define RSSI_INTERVAL_OQPSK_US 8
`define ED_PROCESS_US 12
`define RSSI_CYC_BPSK20 ((`RSSI_INTERVAL_BPSK20_US * 1000) / `CLK_PERIOD_NS)
`define RSSI_CYC_BPSK40 ((`RSSI_INTERVAL_BPSK40_US * 1000) / `CLK_PERIOD_NS)
`define RSSI_CYC_OQPSK ((`RSSI_INTERVAL_OQPSK_US * 1000) / `CLK_PERIOD_NS)
`define ED_PROCESS_CYC ((`ED_PROCESS_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ED_SYMBOLS_STD 4'h8
`define ED_SYMBOLS_HIGH_RATE 4'h2
`define SYMBOL_CYCLES_DEFAULT 800

`endif

// ===== core/fcs_ed_pkg.sv
// Types shared by the frame check and energy detection logic
package fcs_ed_pkg;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_DATA = 4'b0010,
        TX_FCS_HI = 4'b0100,
        TX_FCS_LO = 4'b1000
    } tx_state_t;

    typedef enum logic [2:0] {
        ED_IDLE = 3'b001,
        ED_RUN = 3'b010,
        ED_PROCESS = 3'b100
    } ed_state_t;

    typedef enum logic [1:0] {
        PHY_BPSK20 = 2'h0,
        PHY_BPSK40 = 2'h1,
        PHY_OQPSK = 2'h2
    } phy_mode_t;

    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } octet_t;
endpackage

// ===== core/frame_check_energy.sv
// Frame check sequence, signal strength and energy detection block with its transmit FIFO
//
// Functional notes
// - CRC generator x16 + x12 + x5 + 1
// - Checksum covers octets after length byte
// - Sixteen-bit checksum fills last two octets
// - Check value is remainder of shifted message
// - First message bit and r0 go first
// - Control 0x04 bit 5 enables insertion, resets 1
// - Checksum over N-2 octets replaces last two
// - Every received frame checked, valid flag set
// - Valid result copied into status byte bit 7
// - Valid flag updates at frame end, holds until the next SFD clears it
// - Auto-ack mode drops bad frames, no interrupt
// - Auto-retry treats bad acknowledgement as missing
// - Signal strength refresh interval by PHY mode
// - Signal strength 0 to 28 in bits 4:0
// - Manual measurement eight symbols (two at high rate), then done interrupt
// - SFD detection starts silent automatic measurement
// - Energy ready 8 or 2 symbols plus 12 us
// - Energy value holds until next start
// - Energy range 0x00 to 0x54, reset 0xff
// - Energy averages strength samples over eight symbols, two at high rate
// - Auto-ack manual request raises done, no measurement
`timescale 1ns/1ps
`include "fcs_ed_consts.svh"

module octet_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
        logic not_full;
        logic not_empty;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;
    logic [AW:0] next_count;

    always_comb begin
        next_st = st;
        push = in_valid && st.not_full;
        pop = out_ready && st.not_empty;
        next_count = st.count;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_count = st.count - 1'b1;
        end
        next_st.count = next_count;
        // Flags are registered so that both handshakes stay glitch free
        next_st.not_full = next_count != (AW + 1)'(DEPTH);
        next_st.not_empty = next_count != '0;
        if (!rst_n) begin
            next_st = '0;
            next_st.not_full = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign in_ready = st.not_full;
    assign out_valid = st.not_empty;
    assign out_data = st.mem[st.rd];
endmodule

module frame_check_energy #(
    parameter int SYMBOL_CYCLES = `SYMBOL_CYCLES_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire fcs_ed_pkg::reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    input wire logic TX_START,
    input wire logic [6:0] TX_LEN,
    input wire fcs_ed_pkg::octet_t TX_IN,
    output logic TX_IN_READY,
    output fcs_ed_pkg::octet_t TX_OUT,
    input wire logic TX_OUT_READY,
    input wire logic RX_SFD,
    input wire fcs_ed_pkg::octet_t RX_IN,
    input wire logic RX_LAST,
    output fcs_ed_pkg::octet_t RX_STATUS,
    output logic FRAME_END_IRQ,
    output logic ACK_ACCEPTED,
    output logic ACK_REJECTED,
    input wire logic AUTO_ACK_RECEIVE_MODE,
    input wire logic AUTO_RETRY_TRANSMIT_MODE,
    input wire logic RX_LISTENING,
    input wire logic RX_BUSY,
    input wire logic [1:0] PHY_MODE,
    input wire logic HIGH_RATE,
    input wire logic [4:0] RSSI_SAMPLE,
    output logic CHANNEL_ENERGY_DONE_IRQ
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic crc_valid;
        logic [4:0] rssi;
        logic [7:0] energy;
        logic [7:0] rdata;
        fcs_ed_pkg::tx_state_t tx_st;
        logic [6:0] tx_len;
        logic [6:0] tx_idx;
        logic [15:0] tx_crc;
        logic tx_auto;
        fcs_ed_pkg::octet_t tx_out;
        logic [15:0] rx_crc;
        fcs_ed_pkg::octet_t rx_status;
        logic frame_end;
        logic ack_ok;
        logic ack_bad;
        logic [10:0] rssi_cnt;
        fcs_ed_pkg::ed_state_t ed_st;
        logic [11:0] ed_cnt;
        logic [3:0] ed_nsym;
        logic [7:0] ed_sum;
        logic ed_manual;
        logic ed_irq;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic fifo_pop;
    fcs_ed_pkg::octet_t fifo_out;
    logic slot_free;
    logic rx_good;
    logic [15:0] rx_next_crc;
    logic [10:0] rssi_period;
    logic [4:0] rssi_clamped;
    logic [3:0] ed_symbols;
    logic [9:0] ed_scaled;
    logic rx_on;

    // Bit-serial division, each octet fed LSB first as on air, zero start, no inversion
    function automatic logic [15:0] crc_octet(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = d[i] ^ r[15];
            r = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    // Highest coefficient goes to bit 0 so that r0 leaves first
    function automatic logic [7:0] reverse_octet(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    octet_fifo #(
        .WIDTH(8),
        .DEPTH(16)
    ) tx_fifo (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .in_valid(TX_IN.valid),
        .in_data(TX_IN.data),
        .in_ready(TX_IN_READY),
        .out_valid(fifo_out.valid),
        .out_data(fifo_out.data),
        .out_ready(fifo_pop)
    );

    always_comb begin
        next_st = st;
        fifo_pop = 1'b0;
        rx_on = RX_LISTENING || RX_BUSY;
        slot_free = !st.tx_out.valid || TX_OUT_READY;
        rx_next_crc = crc_octet(st.rx_crc, RX_IN.data);
        rx_good = rx_next_crc == 16'h0000;
        rssi_clamped = (RSSI_SAMPLE > `RSSI_MAX) ? `RSSI_MAX : RSSI_SAMPLE;
        ed_symbols = HIGH_RATE ? `ED_SYMBOLS_HIGH_RATE : `ED_SYMBOLS_STD;
        // Scale 3.1 dB steps to 1.03 dB steps: three times the mean strength, at most 84
        ed_scaled = HIGH_RATE ? 10'((11'(st.ed_sum) * 11'h003) >> 1)
                              : 10'((11'(st.ed_sum) * 11'h003) >> 3);
        case (PHY_MODE)
            fcs_ed_pkg::PHY_BPSK20: rssi_period = 11'(`RSSI_CYC_BPSK20);
            fcs_ed_pkg::PHY_BPSK40: rssi_period = 11'(`RSSI_CYC_BPSK40);
            default: rssi_period = 11'(`RSSI_CYC_OQPSK);
        endcase

        // Register port
        next_st.rdata = 8'h00;
        case (REG_REQ.addr)
            `REG_TRX_CTRL_ONE: next_st.rdata = st.ctrl;
            `REG_SIGNAL_STRENGTH: next_st.rdata = {st.crc_valid, 2'b00, st.rssi};
            `REG_ENERGY_LEVEL: next_st.rdata = st.energy;
            default: next_st.rdata = 8'h00;
        endcase
        if (REG_REQ.wr && REG_REQ.addr == `REG_TRX_CTRL_ONE) begin
            next_st.ctrl = REG_REQ.wdata;
        end

        // Transmit path
        case (st.tx_st)
            fcs_ed_pkg::TX_IDLE: begin
                if (TX_START && TX_LEN != 7'h00) begin
                    next_st.tx_st = fcs_ed_pkg::TX_DATA;
                    next_st.tx_len = TX_LEN;
                    next_st.tx_idx = 7'h00;
                    next_st.tx_crc = `CRC_INIT;
                    next_st.tx_auto = st.ctrl[`CTRL_AUTO_CRC_BIT] && TX_LEN >= `FCS_MIN_LEN;
                end
            end
            fcs_ed_pkg::TX_DATA: begin
                if (slot_free && fifo_out.valid) begin
                    fifo_pop = 1'b1;
                    next_st.tx_out = fifo_out;
                    next_st.tx_crc = crc_octet(st.tx_crc, fifo_out.data);
                    next_st.tx_idx = st.tx_idx + 7'h01;
                    if (st.tx_auto && st.tx_idx + 7'h01 == st.tx_len - 7'h02) begin
                        next_st.tx_st = fcs_ed_pkg::TX_FCS_HI;
                    end else if (!st.tx_auto && st.tx_idx + 7'h01 == st.tx_len) begin
                        next_st.tx_st = fcs_ed_pkg::TX_IDLE;
                    end
                end else if (slot_free) begin
                    next_st.tx_out.valid = 1'b0;
                end
            end
            fcs_ed_pkg::TX_FCS_HI: begin
                // The buffer's own last two octets are drained and replaced
                if (slot_free && fifo_out.valid) begin
                    fifo_pop = 1'b1;
                    next_st.tx_out.valid = 1'b1;
                    next_st.tx_out.data = reverse_octet(st.tx_crc[15:8]);
                    next_st.tx_st = fcs_ed_pkg::TX_FCS_LO;
                end else if (slot_free) begin
                    next_st.tx_out.valid = 1'b0;
                end
            end
            fcs_ed_pkg::TX_FCS_LO: begin
                if (slot_free && fifo_out.valid) begin
                    fifo_pop = 1'b1;
                    next_st.tx_out.valid = 1'b1;
                    next_st.tx_out.data = reverse_octet(st.tx_crc[7:0]);
                    next_st.tx_st = fcs_ed_pkg::TX_IDLE;
                end else if (slot_free) begin
                    next_st.tx_out.valid = 1'b0;
                end
            end
            default: next_st.tx_st = fcs_ed_pkg::TX_IDLE;
        endcase
        if (st.tx_st == fcs_ed_pkg::TX_IDLE && slot_free) begin
            next_st.tx_out.valid = 1'b0;
        end

        // Receive check; residue is zero when the trailing check octets match
        next_st.rx_status.valid = 1'b0;
        next_st.frame_end = 1'b0;
        next_st.ack_ok = 1'b0;
        next_st.ack_bad = 1'b0;
        if (RX_SFD) begin
            next_st.rx_crc = `CRC_INIT;
            next_st.crc_valid = 1'b0;
        end else if (RX_IN.valid) begin
            next_st.rx_crc = rx_next_crc;
            if (RX_LAST) begin
                next_st.crc_valid = rx_good;
                next_st.rx_status.valid = 1'b1;
                next_st.rx_status.data = {rx_good, 7'h00};
                if (AUTO_RETRY_TRANSMIT_MODE) begin
                    next_st.ack_ok = rx_good;
                    next_st.ack_bad = !rx_good;
                end else begin
                    next_st.frame_end = rx_good || !AUTO_ACK_RECEIVE_MODE;
                end
            end
        end

        // Signal strength refresh while any receive state is active
        if (rx_on) begin
            if (st.rssi_cnt >= rssi_period - 11'h001) begin
                next_st.rssi_cnt = 11'h000;
                next_st.rssi = rssi_clamped;
            end else begin
                next_st.rssi_cnt = st.rssi_cnt + 11'h001;
            end
        end else begin
            next_st.rssi_cnt = 11'h000;
        end

        // Energy detection
        next_st.ed_irq = 1'b0;
        case (st.ed_st)
            fcs_ed_pkg::ED_RUN: begin
                if (st.ed_cnt == 12'(SYMBOL_CYCLES - 1)) begin
                    next_st.ed_cnt = 12'h000;
                    next_st.ed_sum = st.ed_sum + 8'(rssi_clamped);
                    next_st.ed_nsym = st.ed_nsym + 4'h1;
                    if (st.ed_nsym + 4'h1 == ed_symbols) begin
                        next_st.ed_st = fcs_ed_pkg::ED_PROCESS;
                    end
                end else begin
                    next_st.ed_cnt = st.ed_cnt + 12'h001;
                end
            end
            fcs_ed_pkg::ED_PROCESS: begin
                if (st.ed_cnt == 12'(`ED_PROCESS_CYC - 1)) begin
                    next_st.ed_st = fcs_ed_pkg::ED_IDLE;
                    next_st.energy = ed_scaled[7:0];
                    next_st.ed_irq = st.ed_manual;
                end else begin
                    next_st.ed_cnt = st.ed_cnt + 12'h001;
                end
            end
            fcs_ed_pkg::ED_IDLE: next_st.ed_cnt = 12'h000;
            default: next_st.ed_st = fcs_ed_pkg::ED_IDLE;
        endcase
        // A new start abandons any measurement in flight
        if (RX_SFD) begin
            next_st.ed_st = fcs_ed_pkg::ED_RUN;
            next_st.ed_manual = 1'b0;
            next_st.ed_cnt = 12'h000;
            next_st.ed_nsym = 4'h0;
            next_st.ed_sum = 8'h00;
        end else if (REG_REQ.wr && REG_REQ.addr == `REG_ENERGY_LEVEL && rx_on) begin
            if (AUTO_ACK_RECEIVE_MODE) begin
                next_st.ed_irq = 1'b1;
            end else begin
                next_st.ed_st = fcs_ed_pkg::ED_RUN;
                next_st.ed_manual = 1'b1;
                next_st.ed_cnt = 12'h000;
                next_st.ed_nsym = 4'h0;
                next_st.ed_sum = 8'h00;
            end
        end

        if (!RSTN) begin
            next_st = '0;
            next_st.ctrl = `CTRL_ONE_RESET;
            next_st.energy = `ENERGY_RESET;
            next_st.tx_st = fcs_ed_pkg::TX_IDLE;
            next_st.ed_st = fcs_ed_pkg::ED_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        st <= next_st;
    end

    assign REG_RDATA = st.rdata;
    assign TX_OUT = st.tx_out;
    assign RX_STATUS = st.rx_status;
    assign FRAME_END_IRQ = st.frame_end;
    assign ACK_ACCEPTED = st.ack_ok;
    assign ACK_REJECTED = st.ack_bad;
    assign CHANNEL_ENERGY_DONE_IRQ = st.ed_irq;
endmodule

// ===== verification/fce_properties.sv
// Port-level assertions for the frame check and energy block
`timescale 1ns/1ps
module fce_properties #(
    parameter int SYMBOL_CYCLES = 10
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire fcs_ed_pkg::reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire fcs_ed_pkg::octet_t TX_OUT,
    input wire logic TX_OUT_READY,
    input wire logic RX_SFD,
    input wire fcs_ed_pkg::octet_t RX_IN,
    input wire logic RX_LAST,
    input wire fcs_ed_pkg::octet_t RX_STATUS,
    input wire logic FRAME_END_IRQ,
    input wire logic ACK_ACCEPTED,
    input wire logic ACK_REJECTED,
    input wire logic AUTO_ACK_RECEIVE_MODE,
    input wire logic AUTO_RETRY_TRANSMIT_MODE,
    input wire logic RX_LISTENING,
    input wire logic RX_BUSY,
    input wire logic CHANNEL_ENERGY_DONE_IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    property p_frame_end;
        RX_IN.valid && RX_LAST && !RX_SFD && !AUTO_ACK_RECEIVE_MODE
            && !AUTO_RETRY_TRANSMIT_MODE |=> FRAME_END_IRQ && RX_STATUS.valid;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame end missing");
    property p_status_src;
        RX_STATUS.valid |-> $past(RX_IN.valid && RX_LAST && !RX_SFD);
    endproperty
    a_status_src: assert property (p_status_src) else $error("stray status");
    property p_status_bits;
        RX_STATUS.valid |-> RX_STATUS.data[6:0] == 7'h00;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits");
    property p_retry;
        RX_IN.valid && RX_LAST && !RX_SFD && AUTO_RETRY_TRANSMIT_MODE && !AUTO_ACK_RECEIVE_MODE
            |=> !FRAME_END_IRQ && (ACK_ACCEPTED != ACK_REJECTED);
    endproperty
    a_retry: assert property (p_retry) else $error("ack verdict missing");
    property p_ack_crc;
        ACK_ACCEPTED || ACK_REJECTED |-> RX_STATUS.valid && RX_STATUS.data[7] == ACK_ACCEPTED;
    endproperty
    a_ack_crc: assert property (p_ack_crc) else $error("ack verdict wrong");
    property p_aack_drop;
        FRAME_END_IRQ && $past(AUTO_ACK_RECEIVE_MODE) |-> RX_STATUS.data[7];
    endproperty
    a_aack_drop: assert property (p_aack_drop) else $error("bad frame passed");
    property p_aack_ed;
        REG_REQ.wr && REG_REQ.addr == 6'h07 && AUTO_ACK_RECEIVE_MODE && !RX_SFD
            && (RX_LISTENING || RX_BUSY) |=> CHANNEL_ENERGY_DONE_IRQ;
    endproperty
    a_aack_ed: assert property (p_aack_ed) else $error("done missing");
    property p_tx_hold;
        TX_OUT.valid && !TX_OUT_READY |=> TX_OUT.valid && $stable(TX_OUT.data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("octet dropped");
    property p_rssi_range;
        REG_REQ.addr == 6'h06 |=> REG_RDATA[4:0] <= 5'h1c && REG_RDATA[6:5] == 2'h0;
    endproperty
    a_rssi_range: assert property (p_rssi_range) else $error("strength range");
    property p_ed_range;
        REG_REQ.addr == 6'h07 |=> REG_RDATA <= 8'h54 || REG_RDATA == 8'hff;
    endproperty
    a_ed_range: assert property (p_ed_range) else $error("energy range");
endmodule

bind frame_check_energy fce_properties #(.SYMBOL_CYCLES(SYMBOL_CYCLES)) u_props (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .TX_OUT(TX_OUT), .TX_OUT_READY(TX_OUT_READY), .RX_SFD(RX_SFD), .RX_IN(RX_IN),
    .RX_LAST(RX_LAST), .RX_STATUS(RX_STATUS), .FRAME_END_IRQ(FRAME_END_IRQ),
    .ACK_ACCEPTED(ACK_ACCEPTED), .ACK_REJECTED(ACK_REJECTED),
    .AUTO_ACK_RECEIVE_MODE(AUTO_ACK_RECEIVE_MODE),
    .AUTO_RETRY_TRANSMIT_MODE(AUTO_RETRY_TRANSMIT_MODE), .RX_LISTENING(RX_LISTENING),
    .RX_BUSY(RX_BUSY), .CHANNEL_ENERGY_DONE_IRQ(CHANNEL_ENERGY_DONE_IRQ));

// ===== verification/host_model.sv
// Host model that drives the register port
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output fcs_ed_pkg::reg_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0;
    // Energy starts are issued both with and without a receive state set by the bench
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk) req <= '{wr: 1'b1, addr: a, wdata: v};
        @(posedge clk) req.wr <= 1'b0;
        req.wdata <= ~v;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk) req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1;
        v = rdata;
    endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the frame check and energy block
`timescale 1ns/1ps
module tb;
    localparam int SYM = 10;
    logic CLK_SYS = 1'b0;
    logic RSTN = 1'b0;
    fcs_ed_pkg::reg_req_t REG_REQ;
    logic [7:0] REG_RDATA;
    logic TX_START = 1'b0;
    logic [6:0] TX_LEN = 7'h00;
    fcs_ed_pkg::octet_t TX_IN = '0;
    fcs_ed_pkg::octet_t TX_OUT;
    fcs_ed_pkg::octet_t RX_IN = '0;
    fcs_ed_pkg::octet_t RX_STATUS;
    logic TX_IN_READY, FRAME_END_IRQ, ACK_ACCEPTED, ACK_REJECTED, CHANNEL_ENERGY_DONE_IRQ;
    logic TX_OUT_READY = 1'b1;
    logic RX_SFD = 1'b0;
    logic RX_LAST = 1'b0;
    logic AUTO_ACK_RECEIVE_MODE = 1'b0;
    logic AUTO_RETRY_TRANSMIT_MODE = 1'b0;
    logic RX_LISTENING = 1'b0;
    logic RX_BUSY = 1'b0;
    logic [1:0] PHY_MODE = 2'h0;
    logic HIGH_RATE = 1'b0;
    logic [4:0] RSSI_SAMPLE = 5'h00;
    int error_cnt = 0;
    int n_checks = 0;
    int n;
    int t;
    logic [31:0] seed = 32'h1155;
    logic [7:0] d, e;
    logic [7:0] sent[$];
    logic [7:0] frm[$];
    logic [7:0] exq[$];

    always #10 CLK_SYS = ~CLK_SYS;
    host_model host (.clk(CLK_SYS), .req(REG_REQ), .rdata(REG_RDATA));
    frame_check_energy #(.SYMBOL_CYCLES(SYM)) dut (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
        .TX_START(TX_START), .TX_LEN(TX_LEN), .TX_IN(TX_IN), .TX_IN_READY(TX_IN_READY),
        .TX_OUT(TX_OUT), .TX_OUT_READY(TX_OUT_READY), .RX_SFD(RX_SFD), .RX_IN(RX_IN),
        .RX_LAST(RX_LAST), .RX_STATUS(RX_STATUS), .FRAME_END_IRQ(FRAME_END_IRQ),
        .ACK_ACCEPTED(ACK_ACCEPTED), .ACK_REJECTED(ACK_REJECTED),
        .AUTO_ACK_RECEIVE_MODE(AUTO_ACK_RECEIVE_MODE),
        .AUTO_RETRY_TRANSMIT_MODE(AUTO_RETRY_TRANSMIT_MODE), .RX_LISTENING(RX_LISTENING),
        .RX_BUSY(RX_BUSY), .PHY_MODE(PHY_MODE), .HIGH_RATE(HIGH_RATE),
        .RSSI_SAMPLE(RSSI_SAMPLE), .CHANNEL_ENERGY_DONE_IRQ(CHANNEL_ENERGY_DONE_IRQ));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
        logic [15:0] c;
        logic fb;
        c = 16'h0000;
        foreach (q[i]) begin
            for (int b = 0; b < 8; b++) begin
                fb = c[15] ^ q[i][b];
                c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
            end
        end
        return c;
    endfunction
    task automatic add_fcs(ref logic [7:0] q[$]);
        logic [15:0] c;
        logic [7:0] h;
        c = crc_of(q);
        h = {<<{c[15:8]}};
        q.push_back(h);
        h = {<<{c[7:0]}};
        q.push_back(h);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Random stalls on the modem side exercise the FIFO holding its head
    always @(posedge CLK_SYS) begin
        if (TX_OUT.valid && TX_OUT_READY) begin
            sent.push_back(TX_OUT.data);
        end
        TX_OUT_READY <= (xs() & 32'h3) != 32'h0;
    end

    task automatic tx_run(input logic [7:0] q[$], input logic [7:0] x[$]);
        sent.delete();
        @(posedge CLK_SYS);
        foreach (q[i]) begin
            TX_IN <= '{valid: 1'b1, data: q[i]};
            do @(posedge CLK_SYS); while (TX_IN_READY !== 1'b1);
        end
        TX_IN <= '0;
        @(posedge CLK_SYS);
        #1;
        if (q.size() == 16) chk(TX_IN_READY, 16'h0);
        @(posedge CLK_SYS) TX_START <= 1'b1;
        TX_LEN <= 7'(q.size());
        @(posedge CLK_SYS) TX_START <= 1'b0;
        for (int k = 0; k < 2000 && sent.size() < x.size(); k++) @(posedge CLK_SYS);
        repeat (6) @(posedge CLK_SYS);
        chk(sent.size(), x.size());
        foreach (x[i]) chk(sent[i], x[i]);
    endtask
    task automatic rx_run(input logic [7:0] q[$], input logic ok, input logic irq);
        @(posedge CLK_SYS) RX_SFD <= 1'b1;
        foreach (q[i]) begin
            @(posedge CLK_SYS) RX_SFD <= 1'b0;
            RX_IN <= '{valid: 1'b1, data: q[i]};
            RX_LAST <= (i == q.size() - 1);
        end
        @(posedge CLK_SYS) RX_IN <= '0;
        RX_LAST <= 1'b0;
        #1;
        chk({RX_STATUS.valid, RX_STATUS.data}, {1'b1, ok, 7'h00});
        chk(FRAME_END_IRQ, irq);
        chk({ACK_ACCEPTED, ACK_REJECTED}, {AUTO_RETRY_TRANSMIT_MODE & ok,
            AUTO_RETRY_TRANSMIT_MODE & !ok});
        host.rd(6'h06, d);
        chk(d[7], ok);
    endtask

    initial begin
        repeat (5) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        host.rd(6'h04, d);
        chk(d, 8'h20);
        host.wr(6'h07, 8'h12);
        host.wr(6'h06, 8'h9f);
        host.rd(6'h07, d);
        chk(d, 8'hff);
        host.rd(6'h06, d);
        chk(d, 8'h00);
        host.rd(6'h3f, d);
        chk(d, 8'h00);
        tx_run({8'h02, 8'h00, 8'h6a, 8'h11, 8'h22}, {8'h02, 8'h00, 8'h6a, 8'he4, 8'h79});
        for (int i = 0; i < 5; i++) begin
            n = (i == 0) ? 16 : (i == 1) ? 3 : 3 + xs() % 14;
            frm.delete();
            repeat (n) frm.push_back(8'(xs()));
            exq = frm[0:n-3];
            add_fcs(exq);
            tx_run(frm, exq);
        end
        host.wr(6'h04, 8'h00);
        host.rd(6'h04, d);
        chk(d, 8'h00);
        tx_run(frm, frm);
        host.wr(6'h04, 8'h20);
        for (int m = 0; m < 7; m++) begin
            frm.delete();
            repeat (2 + xs() % 9) frm.push_back(8'(xs()));
            add_fcs(frm);
            if (m[0]) frm[xs() % frm.size()] ^= 8'h01 << (xs() % 8);
            @(posedge CLK_SYS) AUTO_ACK_RECEIVE_MODE <= (m / 2 == 1);
            AUTO_RETRY_TRANSMIT_MODE <= (m / 2 == 2);
            rx_run(frm, !m[0], m < 3 || m == 6);
        end
        repeat (20) @(posedge CLK_SYS);
        host.rd(6'h06, d);
        chk(d[7], 1'b1);
        @(posedge CLK_SYS) RX_SFD <= 1'b1;
        @(posedge CLK_SYS) RX_SFD <= 1'b0;
        host.rd(6'h06, d);
        chk(d[7], 1'b0);
        @(posedge CLK_SYS) RX_LISTENING <= 1'b1;
        // Mode 3 decodes like mode 2, so it is swept too
        for (int p = 0; p < 4; p++) begin
            d = (p == 0) ? 8'h1f : 8'(xs() % 29);
            @(posedge CLK_SYS) PHY_MODE <= 2'(p);
            RSSI_SAMPLE <= d[4:0];
            repeat ((p == 0) ? 1602 : (p == 1) ? 1202 : 402) @(posedge CLK_SYS);
            host.rd(6'h06, e);
            chk(e[4:0], (d > 8'd28) ? 5'h1c : d[4:0]);
        end
        for (int h = 0; h < 4; h++) begin
            d = 8'(xs() % 29);
            @(posedge CLK_SYS) HIGH_RATE <= h[0];
            RSSI_SAMPLE <= d[4:0];
            if (h < 2) host.wr(6'h07, 8'h5a);
            else RX_SFD <= 1'b1;
            if (h >= 2) @(posedge CLK_SYS) RX_SFD <= 1'b0;
            n = 0;
            t = 0;
            repeat ((h[0] ? 2 : 8) * SYM + 603) begin
                @(posedge CLK_SYS);
                #1;
                n++;
                if (CHANNEL_ENERGY_DONE_IRQ === 1'b1 && t == 0) t = n;
            end
            // Full cycle count: an 8-bit capture would wrap and hide a late result
            n = (h[0] ? 2 : 8) * SYM + 600;
            if (h < 2) chk(16'(t), 16'(n));
            else chk(16'(t), 16'h0000);
            @(posedge CLK_SYS) RSSI_SAMPLE <= ~d[4:0];
            host.rd(6'h07, e);
            chk(e, 8'(3 * d));
        end
        @(posedge CLK_SYS) AUTO_ACK_RECEIVE_MODE <= 1'b1;
        host.wr(6'h07, 8'h00);
        #1;
        chk(CHANNEL_ENERGY_DONE_IRQ, 1'b1);
        repeat (700) @(posedge CLK_SYS);
        host.rd(6'h07, d);
        chk(d, e);
        final_report();
    end

    initial begin
        repeat (40000) @(posedge CLK_SYS);
        error_cnt++;
        final_report();
    end
endmodule
